// ==== cmp_blank_ctrl.sv ====
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module cmp_blank_ctrl (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Mask sources and comparator
	input wire logic [13:0] pwm_outputs,
	input wire logic fault_input_2,
	input wire logic fault_input_4,
	input wire logic [5:0] filter_clock_inputs,
	input wire logic comparator_raw,
	// Analog controls
	output logic [1:0] neg_input_sel,
	output logic [1:0] band_gap_sel,
	output logic pos_ref_source_sel,
	output logic ladder_power_en,
	output logic ladder_pin_out_en,
	output logic ladder_range_sel,
	output logic ladder_supply_sel,
	output logic [3:0] ladder_tap_value,
	// Comparator output
	output logic blank_mask,
	output logic comparator_out
);
	import cmp_blank_pkg::*;

	// ==================================================
	// Registers
	logic [15:0] src_reg, gate_reg, filt_reg, vref_reg, ctrl_reg;
	logic [15:0] next_src, next_gate, next_filt, next_vref, next_ctrl;
	logic [31:0] next_prdata;
	logic [15:0] wr16;
	logic wr_en;

	assign wr16 = pwdata[15:0];
	assign wr_en = psel & penable & pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_comb begin
		next_src = src_reg;
		next_gate = gate_reg;
		next_filt = filt_reg;
		next_vref = vref_reg;
		next_ctrl = ctrl_reg;
		if (wr_en) begin
			case (paddr)
				mask_source_select_off: next_src = wr16 & mask_source_select_wmask;
				mask_gating_control_off: next_gate = wr16 & mask_gating_control_wmask;
				output_filter_control_off: next_filt = wr16 & output_filter_control_wmask;
				voltage_reference_control_off: next_vref = wr16 & voltage_reference_control_wmask;
				comparator_control_off: next_ctrl = wr16 & comparator_control_wmask;
				default: ;
			endcase
		end
	end

	// ==================================================
	// Source decode, shared by the three mask inputs
	function automatic logic pick_source(input logic [3:0] code,
		input logic [13:0] pwm, input logic f2, input logic f4);
		logic r;
		r = 1'b0;
		case (code)
			src_fault_2: r = f2;
			src_fault_4: r = f4;
			default: r = pwm[code];
		endcase
		return r;
	endfunction

	logic mai, mbi, mci, and_a1, or_term, mask;
	assign mai = pick_source(src_reg[mask_a_lsb +: 4], pwm_outputs,
		fault_input_2, fault_input_4);
	assign mbi = pick_source(src_reg[mask_b_lsb +: 4], pwm_outputs,
		fault_input_2, fault_input_4);
	assign mci = pick_source(src_reg[mask_c_lsb +: 4], pwm_outputs,
		fault_input_2, fault_input_4);

	// Enable order: C, /C, B, /B, A, /A from high bit to low bit
	logic [5:0] terms;
	assign terms = {mci, ~mci, mbi, ~mbi, mai, ~mai};
	// Disabled terms become one so they do not pull the AND low
	assign and_a1 = &(terms | ~gate_reg[5:0]);
	assign or_term = |(terms & gate_reg[13:8]);
	// With all enables zero after reset the mask never asserts
	assign mask = or_term | (and_a1 & gate_reg[and_true_to_or_bit])
		| (~and_a1 & gate_reg[and_inv_to_or_bit]);

	// ==================================================
	// Filter clock: pin-level sources are synchronised, then edge detected
	logic [5:0] clk_meta, clk_sync, clk_prev;
	logic [5:0] next_clk_meta, next_clk_sync, next_clk_prev;
	logic cmp_meta, cmp_sync, next_cmp_meta, next_cmp_sync;
	logic [2:0] fsrc;
	logic src_tick, div_tick;
	logic [prescale_width-1:0] pre_cnt, next_pre_cnt, div_mask;

	assign next_clk_meta = filter_clock_inputs;
	assign next_clk_sync = clk_meta;
	assign next_clk_prev = clk_sync;
	assign next_cmp_meta = comparator_raw;
	assign next_cmp_sync = cmp_meta;
	assign fsrc = filt_reg[filter_src_lsb +: 3];
	// Codes 110 and 111 select no clock, so the filter stalls
	assign src_tick = (fsrc < 3'h6) && clk_sync[fsrc] && !clk_prev[fsrc];
	// Divide by 2^code: tick when the low code bits of the counter are zero
	assign div_mask = prescale_width'((8'h01 << filt_reg[filter_div_lsb +: 3]) - 8'h01);
	assign div_tick = src_tick && ((pre_cnt & div_mask) == '0);
	assign next_pre_cnt = src_tick ? pre_cnt + 1'b1 : pre_cnt;

	// ==================================================
	// Divider cross-check: source ticks seen since the last divided tick
	// A new divide code restarts the check, as the counter phase is unknown
	logic [7:0] gap, next_gap;
	logic gap_valid, next_gap_valid;
	logic [7:0] div_ratio;
	assign div_ratio = 8'h01 << filt_reg[filter_div_lsb +: 3];
	always_comb begin
		next_gap = gap;
		next_gap_valid = gap_valid;
		if (div_tick) begin
			next_gap = 8'h00;
			next_gap_valid = 1'b1;
		end else if (src_tick && gap != 8'hff) begin
			next_gap = gap + 8'h01;
		end
		if (wr_en && paddr == output_filter_control_off) begin
			next_gap_valid = 1'b0;
		end
	end

	// ==================================================
	// Digital filter
	logic polarity_out;
	logic [1:0] agree, next_agree;
	filt_state_t fstate, next_fstate;
	assign polarity_out = cmp_sync ^ ctrl_reg[polarity_bit];

	always_comb begin
		next_fstate = fstate;
		next_agree = agree;
		if (div_tick) begin
			case (fstate)
				filt_low: begin
					next_agree = polarity_out ? agree + 2'h1 : 2'h0;
					if (polarity_out && agree == 2'(filter_agree_count - 1)) begin
						next_fstate = filt_high;
						next_agree = 2'h0;
					end
				end
				filt_high: begin
					next_agree = !polarity_out ? agree + 2'h1 : 2'h0;
					if (!polarity_out && agree == 2'(filter_agree_count - 1)) begin
						next_fstate = filt_low;
						next_agree = 2'h0;
					end
				end
				default: next_fstate = filt_low;
			endcase
		end
	end

	logic filtered, deasserted, next_out;
	assign filtered = filt_reg[filter_enable_bit] ? (fstate == filt_high)
		: polarity_out;
	// Mask select set: idle level is one, so a zero is blocked
	assign deasserted = gate_reg[high_low_mask_bit];
	assign next_out = mask ? deasserted : filtered;

	// ==================================================
	// Read mux
	always_comb begin
		next_prdata = 32'h00000000;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				mask_source_select_off: next_prdata = {16'h0000, src_reg};
				mask_gating_control_off: next_prdata = {16'h0000, gate_reg};
				output_filter_control_off: next_prdata = {16'h0000, filt_reg};
				voltage_reference_control_off: next_prdata = {16'h0000, vref_reg};
				comparator_control_off: next_prdata = {16'h0000, ctrl_reg};
				comparator_status_off: next_prdata = {30'h00000000, mask, comparator_out};
				default: next_prdata = 32'h00000000;
			endcase
		end else if (psel && penable) begin
			next_prdata = prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_reg <= reg_reset;
			gate_reg <= reg_reset;
			filt_reg <= reg_reset;
			vref_reg <= reg_reset;
			ctrl_reg <= reg_reset;
			prdata <= 32'h00000000;
			clk_meta <= 6'h00;
			clk_sync <= 6'h00;
			clk_prev <= 6'h00;
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
			pre_cnt <= '0;
			fstate <= filt_low;
			agree <= 2'h0;
			gap <= 8'h00;
			gap_valid <= 1'b0;
			blank_mask <= 1'b0;
			comparator_out <= 1'b0;
		end else begin
			src_reg <= next_src;
			gate_reg <= next_gate;
			filt_reg <= next_filt;
			vref_reg <= next_vref;
			ctrl_reg <= next_ctrl;
			prdata <= next_prdata;
			clk_meta <= next_clk_meta;
			clk_sync <= next_clk_sync;
			clk_prev <= next_clk_prev;
			cmp_meta <= next_cmp_meta;
			cmp_sync <= next_cmp_sync;
			pre_cnt <= next_pre_cnt;
			fstate <= next_fstate;
			agree <= next_agree;
			gap <= next_gap;
			gap_valid <= next_gap_valid;
			blank_mask <= mask;
			comparator_out <= next_out;
		end
	end

	// ==================================================
	// Analog controls, private to this comparator instance
	assign neg_input_sel = ctrl_reg[neg_input_lsb +: 2];
	assign band_gap_sel = vref_reg[band_gap_lsb +: 2];
	assign pos_ref_source_sel = vref_reg[pos_ref_bit];
	assign ladder_power_en = vref_reg[ladder_power_bit];
	assign ladder_pin_out_en = vref_reg[ladder_pin_out_bit];
	assign ladder_range_sel = vref_reg[ladder_range_bit];
	assign ladder_supply_sel = vref_reg[ladder_supply_bit];
	assign ladder_tap_value = vref_reg[tap_lsb +: 4];

	// ==================================================
	// Checks
	chk_mask_holds_out: assert property (@(posedge pclk) disable iff (!presetn)
		mask |=> comparator_out == $past(gate_reg[high_low_mask_bit]))
		else $error("masked output not deasserted");
	chk_bypass_follows: assert property (@(posedge pclk) disable iff (!presetn)
		!mask && !filt_reg[filter_enable_bit] |=> comparator_out == $past(polarity_out))
		else $error("bypass path wrong");
	chk_filter_three: assert property (@(posedge pclk) disable iff (!presetn)
		fstate != $past(fstate) |-> $past(agree) == 2'h2 && $past(div_tick))
		else $error("filter changed early");
	chk_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(src_reg[15:12] == 4'h0) && !gate_reg[14] && (filt_reg[15:7] == 9'h000)
		&& (vref_reg[15:11] == 5'h00))
		else $error("unimplemented bit set");
	chk_or_gate_term: assert property (@(posedge pclk) disable iff (!presetn)
		gate_reg[13] && mci |-> mask)
		else $error("or term ignored");
	chk_and_gate: assert property (@(posedge pclk) disable iff (!presetn)
		gate_reg[13:0] == 14'h0060 |-> mask == mci)
		else $error("and gate wrong");
	chk_fault_src: assert property (@(posedge pclk) disable iff (!presetn)
		src_reg[3:0] == src_fault_4 |-> mai == fault_input_4)
		else $error("fault source wrong");
	chk_div_rate: assert property (@(posedge pclk) disable iff (!presetn)
		div_tick && filt_reg[2:0] != 3'h0 |-> pre_cnt[0] == 1'b0)
		else $error("prescaler wrong");
	chk_div_gap: assert property (@(posedge pclk) disable iff (!presetn)
		div_tick && gap_valid |-> gap == div_ratio - 8'h01)
		else $error("divided tick spacing wrong");
	chk_mask_register: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> blank_mask == $past(mask))
		else $error("blank mask not registered");
	chk_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!div_tick |=> fstate == $past(fstate))
		else $error("filter moved without tick");
	chk_fault_b_src: assert property (@(posedge pclk) disable iff (!presetn)
		src_reg[7:4] == src_fault_2 |-> mbi == fault_input_2)
		else $error("mask b fault source wrong");
endmodule

// ==== cmp_blank_pkg.sv ====
package cmp_blank_pkg;
	// ==================================================
	// Register byte offsets
	localparam logic [7:0] mask_source_select_off = 8'h00;
	localparam logic [7:0] mask_gating_control_off = 8'h04;
	localparam logic [7:0] output_filter_control_off = 8'h08;
	localparam logic [7:0] voltage_reference_control_off = 8'h0c;
	localparam logic [7:0] comparator_control_off = 8'h10;
	localparam logic [7:0] comparator_status_off = 8'h14;
	// ==================================================
	// Writable bit masks (unimplemented bits read zero)
	localparam logic [15:0] mask_source_select_wmask = 16'h0fff;
	localparam logic [15:0] mask_gating_control_wmask = 16'hbfff;
	localparam logic [15:0] output_filter_control_wmask = 16'h007f;
	localparam logic [15:0] voltage_reference_control_wmask = 16'h07ff;
	localparam logic [15:0] comparator_control_wmask = 16'h0007;
	localparam logic [15:0] reg_reset = 16'h0000;
	// ==================================================
	// Field positions
	localparam int mask_a_lsb = 0;
	localparam int mask_b_lsb = 4;
	localparam int mask_c_lsb = 8;
	localparam int high_low_mask_bit = 15;
	localparam int and_true_to_or_bit = 6;
	localparam int and_inv_to_or_bit = 7;
	localparam int filter_div_lsb = 0;
	localparam int filter_enable_bit = 3;
	localparam int filter_src_lsb = 4;
	localparam int tap_lsb = 0;
	localparam int ladder_supply_bit = 4;
	localparam int ladder_range_bit = 5;
	localparam int ladder_pin_out_bit = 6;
	localparam int ladder_power_bit = 7;
	localparam int band_gap_lsb = 8;
	localparam int pos_ref_bit = 10;
	localparam int neg_input_lsb = 0;
	localparam int polarity_bit = 2;
	// ==================================================
	// Codes
	localparam logic [1:0] neg_sel_pin_b = 2'h0;
	localparam logic [1:0] neg_sel_pin_c = 2'h1;
	localparam logic [1:0] neg_sel_pin_d = 2'h2;
	localparam logic [1:0] neg_sel_band_gap = 2'h3;
	localparam logic [3:0] src_fault_2 = 4'he;
	localparam logic [3:0] src_fault_4 = 4'hf;
	localparam int filter_agree_count = 3;
	localparam int prescale_width = 7;
	typedef enum {filt_low, filt_high} filt_state_t;
endpackage

// ==== cmp_src_model.sv ====
`timescale 1ns/1ns
// ==================================================
// Far side: PWM generator outputs and fault inputs
// Outputs change only after a clock edge, as real same-clock sources would
module cmp_src_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Requested source levels: 13:0 PWM, 14 fault 2, 15 fault 4
	input wire logic [15:0] pattern,
	// Mask sources
	output logic [13:0] pwm_outputs,
	output logic fault_input_2,
	output logic fault_input_4
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_outputs <= 14'h0000;
			fault_input_2 <= 1'b0;
			fault_input_4 <= 1'b0;
		end else begin
			pwm_outputs <= pattern[13:0];
			fault_input_2 <= pattern[14];
			fault_input_4 <= pattern[15];
		end
	end
endmodule

// ==== comparator_blanking_filter_ref_ctrl_bench.sv ====
`timescale 1ns/1ns
module comparator_blanking_filter_ref_ctrl_bench;
	import cmp_blank_pkg::*;
	// ==================================================
	// Signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, blank_mask, comparator_out;
	logic comparator_raw = 1'b0;
	logic fclk = 1'b0;
	logic [15:0] pattern = 16'h0000;
	logic [13:0] pwm_outputs;
	logic fault_input_2, fault_input_4;
	logic [1:0] neg_input_sel, band_gap_sel;
	logic pos_ref_source_sel, ladder_power_en, ladder_pin_out_en;
	logic ladder_range_sel, ladder_supply_sel;
	logic [3:0] ladder_tap_value;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	// Rows: source select, gating, source levels, expected mask
	logic [48:0] rows [15] = '{
		{16'h0200, 16'h0060, 16'h0004, 1'b1},
		{16'h0200, 16'h0060, 16'h0000, 1'b0},
		{16'h0000, 16'h0200, 16'h0001, 1'b1},
		{16'h0000, 16'h0200, 16'h0000, 1'b0},
		{16'h000d, 16'h0100, 16'h2000, 1'b0},
		{16'h000d, 16'h0100, 16'h0000, 1'b1},
		{16'h00e0, 16'h0800, 16'h4000, 1'b1},
		{16'h0f00, 16'h2000, 16'h8000, 1'b1},
		{16'h0500, 16'h1000, 16'h0020, 1'b0},
		{16'h0070, 16'h0400, 16'h0000, 1'b1},
		{16'h0210, 16'h006a, 16'h0007, 1'b1},
		{16'h0210, 16'h006a, 16'h0003, 1'b0},
		{16'h0210, 16'h00aa, 16'h0003, 1'b1},
		{16'h0210, 16'h0055, 16'h0000, 1'b1},
		{16'h0210, 16'h0055, 16'h0001, 1'b0}};
	logic [15:0] wm [4] = '{16'h0fff, 16'hbfff, 16'h007f, 16'h07ff};
	logic [15:0] refs [3] = '{16'h07ff, 16'h0245, 16'h0530};
	// ==================================================
	// Design and far side
	cmp_blank_ctrl u_cmp_blank_ctrl (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm_outputs(pwm_outputs),
		.fault_input_2(fault_input_2), .fault_input_4(fault_input_4),
		.filter_clock_inputs({6{fclk}}), .comparator_raw(comparator_raw),
		.neg_input_sel(neg_input_sel), .band_gap_sel(band_gap_sel),
		.pos_ref_source_sel(pos_ref_source_sel),
		.ladder_power_en(ladder_power_en),
		.ladder_pin_out_en(ladder_pin_out_en),
		.ladder_range_sel(ladder_range_sel),
		.ladder_supply_sel(ladder_supply_sel),
		.ladder_tap_value(ladder_tap_value), .blank_mask(blank_mask),
		.comparator_out(comparator_out));
	cmp_src_model u_cmp_src_model (.pclk(pclk), .presetn(presetn),
		.pattern(pattern), .pwm_outputs(pwm_outputs),
		.fault_input_2(fault_input_2), .fault_input_4(fault_input_4));
	// ==================================================
	// Clock, hang guard and tasks
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		comparisons++;
		if (e !== g) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// Waits on pready with no cycle count assumed; the hang guard ends it
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		chk("read data", e, q);
		chk("pslverr", 32'h0, 32'(pslverr));
	endtask
	task automatic tick();
		fclk <= 1'b1;
		repeat (4) @(posedge pclk);
		fclk <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	// ==================================================
	// Sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
		chk("blank_mask", 1'b0, blank_mask);
		foreach (rows[i]) begin
			wr(mask_source_select_off, 32'(rows[i][48:33]));
			wr(mask_gating_control_off, 32'(rows[i][32:17]));
			pattern <= rows[i][16:1];
			repeat (4) @(posedge pclk);
			chk("blank_mask", 32'(rows[i][0]), 32'(blank_mask));
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'(i * 4), 32'hffffffff);
			rd(8'(i * 4), 32'(wm[i]));
			wr(8'(i * 4), 32'h0);
		end
		rd(8'h20, 32'h0);
		foreach (refs[i]) begin
			wr(voltage_reference_control_off, 32'(refs[i]));
			@(posedge pclk);
			chk("ref fields", 32'(refs[i][10:0]), 32'({pos_ref_source_sel,
				band_gap_sel, ladder_power_en, ladder_pin_out_en,
				ladder_range_sel, ladder_supply_sel, ladder_tap_value}));
		end
		for (int i = 0; i < 4; i++) begin
			wr(comparator_control_off, 32'(i));
			@(posedge pclk);
			chk("neg_input_sel", 32'(i), 32'(neg_input_sel));
		end
		wr(comparator_control_off, 32'h0);
		comparator_raw <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("out bypass", 1'b1, comparator_out);
		wr(comparator_control_off, 32'h4);
		repeat (2) @(posedge pclk);
		chk("out inverted", 1'b0, comparator_out);
		wr(comparator_control_off, 32'h0);
		wr(mask_gating_control_off, 32'h0200);
		pattern <= 16'h0001;
		repeat (4) @(posedge pclk);
		chk("out blanked", 1'b0, comparator_out);
		comparator_raw <= 1'b0;
		wr(mask_gating_control_off, 32'h8200);
		repeat (4) @(posedge pclk);
		chk("out blanked", 1'b1, comparator_out);
		rd(comparator_status_off, 32'h3);
		pattern <= 16'h0000;
		wr(mask_gating_control_off, 32'h0);
		repeat (4) @(posedge pclk);
		chk("out unblanked", 1'b0, comparator_out);
		// Slow filter clock so each divided tick is seen once
		wr(output_filter_control_off, 32'h0008);
		repeat (4) tick();
		comparator_raw <= 1'b1;
		repeat (2) tick();
		chk("out two ticks", 1'b0, comparator_out);
		tick();
		repeat (4) @(posedge pclk);
		chk("out three ticks", 1'b1, comparator_out);
		// Divide by two: any four source ticks hold only two samples
		wr(output_filter_control_off, 32'h0009);
		comparator_raw <= 1'b0;
		repeat (4) tick();
		chk("out div two four", 1'b1, comparator_out);
		repeat (2) tick();
		repeat (4) @(posedge pclk);
		chk("out div two six", 1'b0, comparator_out);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(output_filter_control_off, 32'h0);
		chk("out after reset", 1'b0, comparator_out);
		test_done();
	end
endmodule
